// ===== mctc_pkg.sv
// constants and types for the match code teach and compare block
package mctc_pkg;
	// timing
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned DEB_TIME_US = 10000;
	localparam int unsigned DEB_CYC_DFLT = DEB_TIME_US * CLK_MHZ;
	localparam logic [19:0] INIT_WAIT = 20'h00002;
	// repeat-read counts
	localparam logic [5:0] REP_LEARN = 6'h1e;
	localparam logic [5:0] REP_NORMAL = 6'h01;
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_FN = 8'h04;
	localparam logic [7:0] A_PLEN = 8'h08;
	localparam logic [7:0] A_REF2_SL = 8'h0c;
	localparam logic [7:0] A_REF2_D = 8'h10;
	localparam logic [7:0] A_REF1_SL = 8'h14;
	localparam logic [7:0] A_REF1_D = 8'h18;
	localparam logic [7:0] A_STAT = 8'h1c;
	localparam logic [7:0] A_IRQ_ST = 8'h20;
	localparam logic [7:0] A_IRQ_EN = 8'h24;
	localparam logic [7:0] A_IRQ_CLR = 8'h28;
	localparam logic [7:0] A_CNT0 = 8'h2c;
	localparam logic [7:0] A_CNT1 = 8'h30;
	localparam logic [7:0] A_CNT2 = 8'h34;
	// control bit positions
	localparam int CB_TEACH = 0;
	localparam int CB_STATIC = 1;
	localparam int CB_CRST = 2;
	localparam int CB_FILT = 3;
	localparam int CB_PERM = 4;
	localparam int CB_C2 = 5;
	localparam int CB_CPERM = 6;
	// interrupt bit positions
	localparam int IB_LEARN = 0;
	localparam int IB_STORE = 1;
	localparam int IB_MATCH = 2;
	localparam int IB_OPEN = 3;
	// reset values
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [10:0] FN_RST = 11'h010;
	localparam logic [15:0] PLEN_RST = 16'h0032;
	// result functions
	typedef enum logic [2:0] {
		FN_NOMATCH = 3'h0,
		FN_M1 = 3'h1,
		FN_MIS1 = 3'h2,
		FN_M2 = 3'h3,
		FN_MIS2 = 3'h4,
		FN_M1OR2 = 3'h5,
		FN_M1AND2 = 3'h6,
		FN_OFF = 3'h7
	} mctc_fn_e;
	// gray along init, read, learn, held
	typedef enum logic [1:0] {
		ST_INIT = 2'h0,
		ST_READ = 2'h1,
		ST_LEARN = 2'h3,
		ST_HELD = 2'h2
	} mctc_st_e;
	typedef struct packed {
		logic [3:0] sym;
		logic [5:0] len;
		logic [31:0] data;
	} mctc_code_s;
	typedef struct packed {
		logic hsel;
		logic [7:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} mctc_ahb_req_s;
	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} mctc_ahb_rsp_s;
endpackage

// ===== mctc_top.sv
// match code teach-in, storage and comparison with ahb-lite registers
`timescale 1ns/1ps
// Contract
// [R1] parameters not saved permanently: no nv write, defaults after power cycle
// [R2] teach and compare on teach input only when teach function configured
// [R3] leaving parameter mode samples teach level and enables comparison
// [R4] teach input opening in reading mode enters learning of reference one
// [R5] static learning opens read interval automatically, no trigger needed
// [R6] read in learning: one beep, close interval, hold code in ram
// [R7] teach input closing writes type, length, content to nv set
// [R8] after storing, compare every code, drive result two with pulse length
// [R9] close without read ends interval, stored configuration kept
// [R10] opening switch again later re-enters learning, reference replaceable
// [R11] teach input closed at power-up starts with comparison enabled
// [R12] operator keeps switch closed through whole start-up to enable comparison
// [R13] teach input open at power-up: reading mode, comparison disabled
// [R14] seven selectable result functions, reference two ones need it active
// [R15] result one, result two and beeper select functions independently
// [R16] output filter persists apart from comparison enable, applies when active
// [R17] static learning: standard decoder, 30 repeats, then filter by type/length
// [R18] counter reset option clears statistics on each new reference one
// [R19] teach input synchronised and debounced, one event per switch action
module mctc_top #(
	parameter int unsigned DEB_CYC = mctc_pkg::DEB_CYC_DFLT
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire mctc_pkg::mctc_ahb_req_s ahb_req,
	output mctc_pkg::mctc_ahb_rsp_s ahb_rsp,
	input wire logic teach_in,
	input wire logic param_mode,
	input wire logic dec_good,
	input wire logic dec_none,
	input wire mctc_pkg::mctc_code_s dec_code,
	input wire logic nv_valid,
	input wire mctc_pkg::mctc_code_s nv_ref,
	output logic nv_wr,
	output mctc_pkg::mctc_code_s nv_data,
	output logic read_gate,
	output logic std_dec,
	output logic [5:0] rep_cnt,
	output logic code_pass,
	output logic result1,
	output logic result2,
	output logic beep,
	output logic irq
);
	localparam logic [19:0] DEB_LAST = 20'(DEB_CYC - 1);

	typedef struct packed {
		mctc_pkg::mctc_st_e st;
		logic [1:0] sy;
		logic deb;
		logic [19:0] dcnt;
		logic pm;
		logic cmp_en;
		logic gate;
		mctc_pkg::mctc_code_s tmp;
		mctc_pkg::mctc_code_s ref1;
		logic ref1_v;
		logic [6:0] ctrl;
		logic [10:0] fn;
		logic [15:0] plen;
		mctc_pkg::mctc_code_s ref2;
		logic [15:0] pc1;
		logic [15:0] pc2;
		logic [15:0] pcb;
		logic nv_wr;
		logic pass;
		logic [3:0] ist;
		logic [3:0] ien;
		logic [15:0] c_good;
		logic [15:0] c_none;
		logic [15:0] c_int;
		logic [15:0] c_m1;
		logic [15:0] c_m2;
		logic [15:0] c_nom;
		logic wpend;
		logic [7:0] waddr;
		logic [31:0] rdata;
	} mctc_regs_s;

	mctc_regs_s q;
	mctc_regs_s d;

	function automatic logic fn_hit(input logic [2:0] sel, input logic m1, input logic m2,
			input logic a2);
		case (mctc_pkg::mctc_fn_e'(sel))
			mctc_pkg::FN_NOMATCH: fn_hit = !m1 && !m2;
			mctc_pkg::FN_M1: fn_hit = m1;
			mctc_pkg::FN_MIS1: fn_hit = !m1;
			mctc_pkg::FN_M2: fn_hit = a2 && m2;
			mctc_pkg::FN_MIS2: fn_hit = a2 && !m2;
			mctc_pkg::FN_M1OR2: fn_hit = m1 || m2;
			mctc_pkg::FN_M1AND2: fn_hit = a2 && m1 && m2;
			default: fn_hit = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] inc(input logic [15:0] v);
		inc = v + 16'h0001;
	endfunction

	// load on hit, else count down to zero
	function automatic logic [15:0] pulse(input logic hit, input logic [15:0] len,
			input logic [15:0] c);
		if (hit) begin
			pulse = len;
		end else if (c != 16'h0000) begin
			pulse = c - 16'h0001;
		end else begin
			pulse = 16'h0000;
		end
	endfunction

	// decoded control and events
	logic teach_fn;
	logic is_static;
	logic cmp_on;
	logic chg;
	logic open_ev;
	logic close_ev;
	logic m1;
	logic m2;
	logic a2;
	logic symlen_ok;
	logic cmp_go;
	logic store;
	logic a_phase;
	logic [3:0] clr;
	assign teach_fn = q.ctrl[mctc_pkg::CB_TEACH];
	assign is_static = q.ctrl[mctc_pkg::CB_STATIC];
	assign a2 = q.ctrl[mctc_pkg::CB_C2];
	assign cmp_on = q.cmp_en || q.ctrl[mctc_pkg::CB_CPERM];
	// [R19] stable for full debounce time
	assign chg = (q.st != mctc_pkg::ST_INIT) && (q.sy[1] != q.deb) && (q.dcnt == DEB_LAST);
	assign open_ev = chg && q.deb;
	assign close_ev = chg && !q.deb;
	assign m1 = q.ref1_v && (dec_code == q.ref1);
	assign m2 = a2 && (dec_code == q.ref2);
	assign symlen_ok = q.ref1_v && dec_code.sym == q.ref1.sym && dec_code.len == q.ref1.len;
	assign cmp_go = dec_good && cmp_on && (q.st == mctc_pkg::ST_READ);
	assign store = teach_fn && close_ev && (q.st == mctc_pkg::ST_HELD);
	assign a_phase = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
	assign clr = (q.wpend && q.waddr == mctc_pkg::A_IRQ_CLR) ? ahb_req.hwdata[3:0] : 4'h0;

	// next state of everything
	always_comb begin
		d = q;
		d.nv_wr = 1'b0;
		d.pass = 1'b0;
		// only this cycle's events here, old bits merged below
		d.ist = 4'h0;
		d.sy = {q.sy[0], teach_in};
		d.pm = param_mode;
		if (q.st == mctc_pkg::ST_INIT) begin
			// wait for the synchroniser to fill before catching the level
			d.dcnt = q.dcnt + 20'h00001;
			if (q.dcnt == mctc_pkg::INIT_WAIT) begin
				d.dcnt = 20'h00000;
				d.deb = q.sy[1];
				// [R11] closed at power-up
				// [R13] open at power-up
				d.cmp_en = teach_fn && q.sy[1];
				// [R1] only a permanent image survives
				d.ref1_v = nv_valid;
				d.ref1 = nv_valid ? nv_ref : '0;
				d.st = mctc_pkg::ST_READ;
			end
		end else if (q.sy[1] == q.deb) begin
			d.dcnt = 20'h00000;
		end else if (chg) begin
			// [R19] one event per change
			d.deb = q.sy[1];
			d.dcnt = 20'h00000;
		end else begin
			d.dcnt = q.dcnt + 20'h00001;
		end
		// teach state machine
		case (q.st)
			mctc_pkg::ST_INIT: begin
				d.gate = 1'b0;
			end
			mctc_pkg::ST_READ: begin
				if (teach_fn && q.pm && !param_mode) begin
					// [R3] sample on return to reading
					d.cmp_en = q.deb;
				end
				// [R4] open enters learning
				// [R10] also later, to replace
				if (teach_fn && open_ev && !param_mode) begin
					d.st = mctc_pkg::ST_LEARN;
					// [R5] static opens interval itself
					d.gate = is_static;
					d.ist[mctc_pkg::IB_OPEN] = 1'b1;
				end
			end
			mctc_pkg::ST_LEARN: begin
				if (close_ev) begin
					// [R9] no read: just end interval
					d.gate = 1'b0;
					d.st = mctc_pkg::ST_READ;
				end else if (dec_good) begin
					// [R6] tone, close interval, hold
					d.tmp = dec_code;
					d.gate = 1'b0;
					d.st = mctc_pkg::ST_HELD;
					d.ist[mctc_pkg::IB_LEARN] = 1'b1;
				end
			end
			mctc_pkg::ST_HELD: begin
				if (store) begin
					// [R7] keep reference, write nv
					d.ref1 = q.tmp;
					d.ref1_v = 1'b1;
					// [R1] skip nv when not saved permanently
					d.nv_wr = q.ctrl[mctc_pkg::CB_PERM];
					// [R8] compare from now on
					d.cmp_en = 1'b1;
					d.st = mctc_pkg::ST_READ;
					d.ist[mctc_pkg::IB_STORE] = 1'b1;
				end
			end
			default: begin
				d.st = mctc_pkg::ST_INIT;
			end
		endcase
		// [R14] function select
		// [R15] each output its own select
		// [R8] result two pulse with set length
		d.pc1 = pulse(cmp_go && fn_hit(q.fn[2:0], m1, m2, a2), q.plen, q.pc1);
		d.pc2 = pulse(cmp_go && fn_hit(q.fn[6:4], m1, m2, a2), q.plen, q.pc2);
		// [R6] learning tone shares the beeper
		d.pcb = pulse((cmp_go && fn_hit(q.fn[10:8], m1, m2, a2))
			|| (q.st == mctc_pkg::ST_LEARN && dec_good && !close_ev), q.plen, q.pcb);
		if (cmp_go && m1) begin
			d.ist[mctc_pkg::IB_MATCH] = 1'b1;
		end
		// [R16] filter kept apart, applies while comparing
		// [R17] static reference filters by type and length
		if (dec_good && q.st == mctc_pkg::ST_READ) begin
			d.pass = !(cmp_on && (q.ctrl[mctc_pkg::CB_FILT] || is_static)) || symlen_ok;
		end
		// statistics
		if (dec_good) begin
			d.c_good = inc(q.c_good);
		end
		if (dec_none) begin
			d.c_none = inc(q.c_none);
		end
		if (dec_good || dec_none) begin
			d.c_int = inc(q.c_int);
		end
		if (cmp_go && m1) begin
			d.c_m1 = inc(q.c_m1);
		end
		if (cmp_go && m2) begin
			d.c_m2 = inc(q.c_m2);
		end
		if (cmp_go && !m1 && !m2) begin
			d.c_nom = inc(q.c_nom);
		end
		// [R18] new reference clears statistics
		if (store && q.ctrl[mctc_pkg::CB_CRST]) begin
			d.c_good = 16'h0000;
			d.c_none = 16'h0000;
			d.c_int = 16'h0000;
			d.c_m1 = 16'h0000;
			d.c_m2 = 16'h0000;
			d.c_nom = 16'h0000;
		end
		// sticky status: a set in the clear cycle wins
		d.ist = d.ist | (q.ist & ~clr);
		// bus data phase write
		if (q.wpend) begin
			case (q.waddr)
				mctc_pkg::A_CTRL: d.ctrl = ahb_req.hwdata[6:0];
				mctc_pkg::A_FN: d.fn = ahb_req.hwdata[10:0];
				mctc_pkg::A_PLEN: d.plen = ahb_req.hwdata[15:0];
				mctc_pkg::A_REF2_SL: d.ref2[41:32] = ahb_req.hwdata[9:0];
				mctc_pkg::A_REF2_D: d.ref2.data = ahb_req.hwdata;
				mctc_pkg::A_IRQ_EN: d.ien = ahb_req.hwdata[3:0];
				default: d.ien = q.ien;
			endcase
		end
		// bus address phase, read data ready for the data phase
		d.wpend = a_phase && ahb_req.hwrite;
		d.waddr = ahb_req.haddr;
		if (a_phase && !ahb_req.hwrite) begin
			case (ahb_req.haddr)
				mctc_pkg::A_CTRL: d.rdata = {25'h0000000, q.ctrl};
				mctc_pkg::A_FN: d.rdata = {21'h000000, q.fn};
				mctc_pkg::A_PLEN: d.rdata = {16'h0000, q.plen};
				mctc_pkg::A_REF2_SL: d.rdata = {22'h000000, q.ref2[41:32]};
				mctc_pkg::A_REF2_D: d.rdata = q.ref2.data;
				mctc_pkg::A_REF1_SL: d.rdata = {21'h000000, q.ref1_v, q.ref1[41:32]};
				mctc_pkg::A_REF1_D: d.rdata = q.ref1.data;
				mctc_pkg::A_STAT: d.rdata = {27'h0000000, cmp_on, q.gate, q.deb, q.st};
				mctc_pkg::A_IRQ_ST: d.rdata = {28'h0000000, q.ist};
				mctc_pkg::A_IRQ_EN: d.rdata = {28'h0000000, q.ien};
				mctc_pkg::A_CNT0: d.rdata = {q.c_none, q.c_good};
				mctc_pkg::A_CNT1: d.rdata = {q.c_m2, q.c_m1};
				mctc_pkg::A_CNT2: d.rdata = {q.c_int, q.c_nom};
				default: d.rdata = 32'h00000000;
			endcase
		end
	end

	// single state register, frozen while ce is low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.ctrl <= mctc_pkg::CTRL_RST;
			q.fn <= mctc_pkg::FN_RST;
			q.plen <= mctc_pkg::PLEN_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	// outputs
	assign ahb_rsp.hrdata = q.rdata;
	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp = 1'b0;
	assign nv_wr = q.nv_wr;
	assign nv_data = q.ref1;
	assign read_gate = q.gate;
	// [R17] standard decoder and 30 repeats while learning statically
	assign std_dec = (q.st == mctc_pkg::ST_LEARN) && is_static;
	assign rep_cnt = std_dec ? mctc_pkg::REP_LEARN : mctc_pkg::REP_NORMAL;
	assign code_pass = q.pass;
	assign result1 = q.pc1 != 16'h0000;
	assign result2 = q.pc2 != 16'h0000;
	assign beep = q.pcb != 16'h0000;
	assign irq = |(q.ist & q.ien);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_learn_read; // [R6]
		ce && q.st == mctc_pkg::ST_LEARN && dec_good && !close_ev
			|=> q.st == mctc_pkg::ST_HELD && !read_gate && beep && q.tmp == $past(dec_code);
	endproperty
	a_learn_read: assert property (p_learn_read) else $error("learn read not held");

	property p_no_read_close; // [R9]
		ce && q.st == mctc_pkg::ST_LEARN && close_ev
			|=> q.st == mctc_pkg::ST_READ && q.ref1 == $past(q.ref1) && !read_gate;
	endproperty
	a_no_read_close: assert property (p_no_read_close) else $error("reference changed");

	property p_store; // [R7]
		ce && store |=> q.ref1 == $past(q.tmp) && q.ref1_v && q.cmp_en;
	endproperty
	a_store: assert property (p_store) else $error("reference not stored");

	property p_enter_learn; // [R4]
		ce && q.st == mctc_pkg::ST_READ && teach_fn && open_ev && !param_mode
			|=> q.st == mctc_pkg::ST_LEARN && read_gate == $past(is_static);
	endproperty
	a_enter_learn: assert property (p_enter_learn) else $error("learning not entered");

	property p_teach_off; // [R2]
		q.st == mctc_pkg::ST_READ && !teach_fn |=> q.st != mctc_pkg::ST_LEARN;
	endproperty
	a_teach_off: assert property (p_teach_off) else $error("learning without function");

	property p_repeat; // [R17]
		q.st == mctc_pkg::ST_LEARN && is_static |-> rep_cnt == 6'h1e && std_dec;
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat count wrong");

	property p_nv_perm; // [R1]
		nv_wr |-> q.ctrl[mctc_pkg::CB_PERM] && $past(q.st) == mctc_pkg::ST_HELD;
	endproperty
	a_nv_perm: assert property (p_nv_perm) else $error("nv write not permanent");

	property p_cnt_clr; // [R18]
		ce && store && q.ctrl[mctc_pkg::CB_CRST] |=> q.c_good == 16'h0000 && q.c_m1 == 16'h0000;
	endproperty
	a_cnt_clr: assert property (p_cnt_clr) else $error("counters not cleared");

	property p_param_exit; // [R3]
		ce && q.st == mctc_pkg::ST_READ && teach_fn && q.pm && !param_mode && !open_ev
			|=> q.cmp_en == $past(q.deb);
	endproperty
	a_param_exit: assert property (p_param_exit) else $error("compare not sampled");

	property p_result2; // [R8]
		ce && cmp_go && fn_hit(q.fn[6:4], m1, m2, a2) && q.plen != 16'h0000
			|=> result2 && q.pc2 == $past(q.plen);
	endproperty
	a_result2: assert property (p_result2) else $error("result two not pulsed");

endmodule // mctc_top

// ===== mctc_partner.sv
// operator switch and decoder model facing the teach block
`timescale 1ns/1ps
module mctc_partner (
	input wire logic clk_sys,
	output logic teach_in,
	output logic dec_good,
	output logic dec_none,
	output mctc_pkg::mctc_code_s dec_code
);
	// idle state: switch open, decoder quiet
	initial begin
		teach_in = 1'b0;
		dec_good = 1'b0;
		dec_none = 1'b0;
		dec_code = '0;
	end

	// switch held steady
	// level moves only on request, never during start-up
	task automatic set_switch(input logic closed);
		@(posedge clk_sys);
		teach_in <= closed;
	endtask

	// one decoded code after dly cycles, prompt or slow
	task automatic read_code(input mctc_pkg::mctc_code_s c, input int dly);
		repeat (dly) @(posedge clk_sys);
		@(posedge clk_sys);
		dec_good <= 1'b1;
		dec_code <= c;
		@(posedge clk_sys);
		dec_good <= 1'b0;
		// code lines not held after the pulse
		dec_code <= ~c;
	endtask

	// interval that ended without a read
	task automatic no_read();
		@(posedge clk_sys);
		dec_none <= 1'b1;
		@(posedge clk_sys);
		dec_none <= 1'b0;
	endtask
endmodule // mctc_partner

// ===== mctc_top_tb.sv
// self-checking bench for the match code teach and compare block
`timescale 1ns/1ps
module mctc_top_tb;
	localparam int unsigned DEB = 4;
	localparam logic [15:0] PLEN = 16'h0005;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic param_mode = 1'b0;
	logic nv_valid = 1'b0;
	mctc_pkg::mctc_code_s nv_ref = '0;
	mctc_pkg::mctc_ahb_req_s ahb_req = '0;
	mctc_pkg::mctc_ahb_req_s bus_req;
	mctc_pkg::mctc_ahb_rsp_s ahb_rsp;
	logic teach_in, dec_good, dec_none, nv_wr, read_gate, std_dec, code_pass;
	logic result1, result2, beep, irq;
	logic [5:0] rep_cnt;
	mctc_pkg::mctc_code_s dec_code, nv_data, nv_last, code_a, code_b, code_c;
	logic [15:0] cnt [4];
	logic [31:0] rd;
	int num_errors = 0;
	int comparisons = 0;
	int seed = 19;
	int cycles = 0;
	int nv_wr_cnt = 0;

	always #10 clk_sys = ~clk_sys;
	// single slave, so its ready is the bus ready
	always_comb begin
		bus_req = ahb_req;
		bus_req.hready = ahb_rsp.hreadyout;
	end

	mctc_top #(.DEB_CYC(DEB)) mctc_top_i (
		.clk_sys(clk_sys), .rst(rst), .ce(ce), .ahb_req(bus_req), .ahb_rsp(ahb_rsp),
		.teach_in(teach_in), .param_mode(param_mode), .dec_good(dec_good),
		.dec_none(dec_none), .dec_code(dec_code), .nv_valid(nv_valid), .nv_ref(nv_ref),
		.nv_wr(nv_wr), .nv_data(nv_data), .read_gate(read_gate), .std_dec(std_dec),
		.rep_cnt(rep_cnt), .code_pass(code_pass), .result1(result1), .result2(result2),
		.beep(beep), .irq(irq)
	);
	mctc_partner mctc_partner_i (
		.clk_sys(clk_sys), .teach_in(teach_in), .dec_good(dec_good),
		.dec_none(dec_none), .dec_code(dec_code)
	);

	// nv write monitor, keeps the last image written
	always @(posedge clk_sys) begin
		if (nv_wr === 1'b1) begin
			nv_wr_cnt <= nv_wr_cnt + 1;
			nv_last <= nv_data;
		end
	end

	// hang guard, far above the expected run length
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic check(input logic [41:0] seen, input logic [41:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// single word transfer: address phase, then data phase
	task automatic ahb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		ahb_req.hsel <= 1'b1;
		ahb_req.haddr <= a;
		ahb_req.htrans <= 2'b10;
		ahb_req.hwrite <= w;
		ahb_req.hsize <= 3'h2;
		do @(posedge clk_sys); while (bus_req.hready !== 1'b1);
		ahb_req.hsel <= 1'b0;
		ahb_req.htrans <= 2'b00;
		ahb_req.hwdata <= d;
		do @(posedge clk_sys); while (bus_req.hready !== 1'b1);
		rd = ahb_rsp.hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb_xfer(a, 1'b1, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		ahb_xfer(a, 1'b0, 32'h0);
		check(rd & m, e);
	endtask

	// bounded wait for the reading interval gate
	task automatic wait_gate(input logic lvl);
		int n;
		n = 0;
		while (read_gate !== lvl && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
		check(read_gate, lvl);
	endtask

	// high-cycle counts of the pulsed outputs after one read
	task automatic pulses();
		cnt = '{default: 16'h0};
		repeat (PLEN + 3) begin
			@(negedge clk_sys);
			cnt[0] += 16'(result1);
			cnt[1] += 16'(result2);
			cnt[2] += 16'(beep);
			cnt[3] += 16'(code_pass);
		end
	endtask

	function automatic logic fn_out(input logic [2:0] f, input logic m1, input logic m2);
		case (f)
			3'h0: fn_out = !m1 && !m2;
			3'h1: fn_out = m1;
			3'h2: fn_out = !m1;
			3'h3: fn_out = m2;
			3'h4: fn_out = !m2;
			3'h5: fn_out = m1 || m2;
			3'h6: fn_out = m1 && m2;
			default: fn_out = 1'b0;
		endcase
	endfunction

	// one compare; result1 runs the mirror function 6 - f, so both differ except at f = 3
	task automatic cmp_code(input mctc_pkg::mctc_code_s c, input logic [2:0] f);
		logic m1, m2, ok;
		m1 = (c == code_a);
		m2 = (c == code_c);
		ok = (c.sym == code_a.sym) && (c.len == code_a.len);
		mctc_partner_i.read_code(c, int'(f));
		pulses();
		check(cnt[0], fn_out(3'h6 - f, m1, m2) ? PLEN : 16'h0);
		check(cnt[1], fn_out(f, m1, m2) ? PLEN : 16'h0);
		check(cnt[2], fn_out(f, m1, m2) ? PLEN : 16'h0);
		check(cnt[3], 16'(ok));
	endtask

	// main sequence
	initial begin
		code_a = 42'({$random(seed), $random(seed)});
		code_b = code_a;
		code_b.len = code_a.len + 6'h01;
		code_c = code_a;
		code_c.data = ~code_a.data;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd_chk(mctc_pkg::A_STAT, 32'h1f, 32'h01);
		rd_chk(mctc_pkg::A_CTRL, 32'hffffffff, 32'h0);
		rd_chk(mctc_pkg::A_FN, 32'hffffffff, 32'h010);
		rd_chk(mctc_pkg::A_PLEN, 32'hffffffff, 32'h32);
		rd_chk(8'h3c, 32'hffffffff, 32'h0);
		$display("reset values done");
		wr(mctc_pkg::A_CTRL, 32'h37);
		wr(mctc_pkg::A_PLEN, 32'(PLEN));
		wr(mctc_pkg::A_IRQ_EN, 32'hf);
		wr(mctc_pkg::A_REF2_SL, {22'h0, code_c.sym, code_c.len});
		wr(mctc_pkg::A_REF2_D, code_c.data);
		mctc_partner_i.set_switch(1'b1);
		repeat (DEB + 8) @(posedge clk_sys);
		param_mode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		param_mode <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd_chk(mctc_pkg::A_STAT, 32'h10, 32'h10);
		$display("parameter mode exit done");
		mctc_partner_i.set_switch(1'b0);
		wait_gate(1'b1);
		check(rep_cnt, mctc_pkg::REP_LEARN);
		check(std_dec, 1'b1);
		check(irq, 1'b1);
		mctc_partner_i.read_code(code_a, 3);
		pulses();
		check(cnt[2], PLEN);
		check(read_gate, 1'b0);
		mctc_partner_i.set_switch(1'b1);
		while (nv_wr_cnt == 0 && cycles < 2000) @(negedge clk_sys);
		check(nv_last, code_a);
		rd_chk(mctc_pkg::A_REF1_SL, 32'h3ff, {22'h0, code_a.sym, code_a.len});
		rd_chk(mctc_pkg::A_REF1_D, 32'hffffffff, code_a.data);
		$display("learn and store done");
		for (int f = 0; f < 7; f++) begin
			wr(mctc_pkg::A_FN, {21'h0, 3'(f), 1'b0, 3'(f), 1'b0, 3'(6 - f)});
			cmp_code(code_a, 3'(f));
			cmp_code(code_c, 3'(f));
			cmp_code(code_b, 3'(f));
		end
		$display("compare functions done");
		rd_chk(mctc_pkg::A_IRQ_ST, 32'hf, 32'hf);
		wr(mctc_pkg::A_IRQ_EN, 32'h0);
		@(negedge clk_sys);
		check(irq, 1'b0);
		wr(mctc_pkg::A_IRQ_EN, 32'hf);
		wr(mctc_pkg::A_IRQ_CLR, 32'hf);
		rd_chk(mctc_pkg::A_IRQ_ST, 32'hf, 32'h0);
		rd_chk(mctc_pkg::A_IRQ_CLR, 32'hffffffff, 32'h0);
		check(irq, 1'b0);
		$display("interrupt done");
		wr(mctc_pkg::A_CTRL, 32'h27);
		mctc_partner_i.set_switch(1'b0);
		wait_gate(1'b1);
		mctc_partner_i.read_code(code_b, 0);
		mctc_partner_i.set_switch(1'b1);
		wait_gate(1'b0);
		repeat (DEB + 8) @(posedge clk_sys);
		check(nv_wr_cnt, 1);
		rd_chk(mctc_pkg::A_CNT1, 32'hffffffff, 32'h0);
		rd_chk(mctc_pkg::A_REF1_D, 32'hffffffff, code_b.data);
		mctc_partner_i.set_switch(1'b0);
		wait_gate(1'b1);
		mctc_partner_i.set_switch(1'b1);
		wait_gate(1'b0);
		rd_chk(mctc_pkg::A_REF1_SL, 32'h3ff, {22'h0, code_b.sym, code_b.len});
		$display("replace and abort done");
		wr(mctc_pkg::A_CTRL, 32'h26);
		mctc_partner_i.set_switch(1'b0);
		repeat (DEB + 8) @(posedge clk_sys);
		check(read_gate, 1'b0);
		rd_chk(mctc_pkg::A_STAT, 32'h3, 32'h1);
		$display("teach function off done");
		// filter alone, without static teach, still gates output
		wr(mctc_pkg::A_CTRL, 32'h08);
		mctc_partner_i.read_code(code_a, 0);
		pulses();
		check(cnt[3], 16'h0000);
		mctc_partner_i.read_code(code_b, 0);
		pulses();
		check(cnt[3], 16'h0001);
		// a read while ce is low must leave every counter alone
		@(posedge clk_sys);
		ce <= 1'b0;
		mctc_partner_i.read_code(code_b, 0);
		ce <= 1'b1;
		mctc_partner_i.no_read();
		rd_chk(mctc_pkg::A_CNT0, 32'hffffffff, 32'h00010002);
		rd_chk(mctc_pkg::A_CNT1, 32'hffffffff, 32'h00000001);
		rd_chk(mctc_pkg::A_CNT2, 32'hffffffff, 32'h00030001);
		$display("filter and clock enable done");
		// mid-run reset with a saved image: only the permanent reference returns
		nv_valid <= 1'b1;
		nv_ref <= code_c;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd_chk(mctc_pkg::A_REF1_D, 32'hffffffff, code_c.data);
		rd_chk(mctc_pkg::A_REF1_SL, 32'h7ff, {21'h0, 1'b1, code_c.sym, code_c.len});
		rd_chk(mctc_pkg::A_CTRL, 32'hffffffff, 32'h0);
		rd_chk(mctc_pkg::A_STAT, 32'h1f, 32'h01);
		$display("second reset done");
		finish_test();
	end
endmodule // mctc_top_tb
